// [hdl/tsr_status_slave.sv]
// 2-wire slave that serves the one-byte device status register
`timescale 1ns/1ps
module tsr_status_slave #(
    parameter logic [7:0] SLAVE_ADDR = tsr_pkg::DEV_ADDR_RST
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic cmd_start_i,
    input wire logic cmd_done_i,
    input wire logic cmd_has_output_i,
    input wire logic [2:0] cmd_err_i,
    input wire logic processing_i,
    input wire logic penalty_i,
    input wire logic challenge_ok_i,
    output logic [7:0] status_o,
    output logic busy_o,
    output logic cmd_addr_hit_o
);
    logic scl_f;
    logic sda_f;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    tsr_pkg::tsr_bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] addr_sr;
    logic [7:0] tx_sr;
    logic data_avail;
    logic verified;
    logic [2:0] err_code;
    logic busy;
    logic addr_match;
    logic addr_sel;
    logic addr_rd;
    logic addr_ack;

    // Codes outside the documented set report as malformed
    function automatic logic [2:0] legal_code(input logic [2:0] code);
        case (code)
            tsr_pkg::ERR_OK, tsr_pkg::ERR_RESET_LOCKOUT, tsr_pkg::ERR_MALFORMED,
            tsr_pkg::ERR_PENALTY_WAIT, tsr_pkg::ERR_AUTH_FAIL:
                legal_code = code;
            default:
                legal_code = tsr_pkg::ERR_MALFORMED;
        endcase
    endfunction

    tsr_pin_sync #(.STAGES(tsr_pkg::SYNC_STAGES), .INIT(1'b1)) u_scl_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(scl_i),
        .level_o(scl_f)
    );

    tsr_pin_sync #(.STAGES(tsr_pkg::SYNC_STAGES), .INIT(1'b1)) u_sda_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(sda_i),
        .level_o(sda_f)
    );

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign start_seen = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_seen = scl_f & scl_d & ~sda_d & sda_f;

    // Status contents
    assign busy = processing_i | penalty_i | (err_code == tsr_pkg::ERR_RESET_LOCKOUT)
        | (err_code == tsr_pkg::ERR_PENALTY_WAIT);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            data_avail <= 1'b0;
        else if (cmd_done_i)
            data_avail <= cmd_has_output_i;
        else if (cmd_start_i)
            data_avail <= 1'b0;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            verified <= 1'b0;
        else if (challenge_ok_i)
            verified <= 1'b1;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            err_code <= tsr_pkg::ERR_OK;
        else if (cmd_done_i)
            err_code <= legal_code(cmd_err_i);
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            status_o <= tsr_pkg::STATUS_RST;
            busy_o <= 1'b0;
        end
        else
        begin
            status_o[tsr_pkg::ST_AVAIL_BIT] <= data_avail;
            status_o[tsr_pkg::ST_BUSY_BIT] <= busy;
            status_o[tsr_pkg::ST_VERIFIED_BIT] <= verified;
            status_o[tsr_pkg::ST_RSVD_MSB:tsr_pkg::ST_RSVD_LSB] <= 2'h0;
            status_o[tsr_pkg::ST_ERR_MSB:tsr_pkg::ST_ERR_LSB] <= err_code;
            busy_o <= busy;
        end
    end

    // Address decode
    assign addr_match = addr_sr[7:tsr_pkg::ADDR_CMP_LSB] == SLAVE_ADDR[7:tsr_pkg::ADDR_CMP_LSB];
    assign addr_sel = addr_sr[tsr_pkg::ADDR_SEL_BIT];
    assign addr_rd = addr_sr[tsr_pkg::ADDR_RW_BIT];
    assign addr_ack = addr_match & (addr_sel ? addr_rd : ~busy_o);

    // Bus sequencer
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state <= tsr_pkg::BUS_IDLE;
            bit_cnt <= 4'h0;
            addr_sr <= 8'h00;
            tx_sr <= 8'h00;
            sda_oe_o <= 1'b0;
            cmd_addr_hit_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            cmd_addr_hit_o <= 1'b0;
            sda_o <= 1'b0; // Open drain, only pulls low
            if (start_seen)
            begin
                state <= tsr_pkg::BUS_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= tsr_pkg::BUS_IDLE;
                sda_oe_o <= 1'b0;
            end
            else
            begin
                case (state)
                    tsr_pkg::BUS_IDLE:
                        sda_oe_o <= 1'b0;
                    tsr_pkg::BUS_ADDR:
                    begin
                        if (scl_rise && bit_cnt != tsr_pkg::BYTE_BITS)
                        begin
                            addr_sr <= {addr_sr[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall && bit_cnt == tsr_pkg::BYTE_BITS)
                        begin
                            state <= addr_ack ? tsr_pkg::BUS_ACK : tsr_pkg::BUS_SKIP;
                            sda_oe_o <= addr_ack;
                        end
                    end
                    tsr_pkg::BUS_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt <= 4'h0;
                            if (addr_sel)
                            begin
                                tx_sr <= status_o;
                                sda_oe_o <= ~status_o[7];
                                state <= tsr_pkg::BUS_SEND;
                            end
                            else
                            begin
                                cmd_addr_hit_o <= 1'b1;
                                sda_oe_o <= 1'b0;
                                state <= tsr_pkg::BUS_SKIP;
                            end
                        end
                    end
                    tsr_pkg::BUS_SEND:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                            tx_sr <= {tx_sr[6:0], 1'b0};
                            if (bit_cnt == tsr_pkg::LAST_BIT)
                            begin
                                sda_oe_o <= 1'b0;
                                state <= tsr_pkg::BUS_SKIP;
                            end
                            else
                                sda_oe_o <= ~tx_sr[6];
                        end
                    end
                    tsr_pkg::BUS_SKIP:
                        sda_oe_o <= 1'b0;
                    default:
                    begin
                        state <= tsr_pkg::BUS_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    property p_reserved_zero;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        status_o[tsr_pkg::ST_RSVD_MSB:tsr_pkg::ST_RSVD_LSB] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero");

    property p_lock_codes_busy;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (status_o[7:5] == tsr_pkg::ERR_RESET_LOCKOUT || status_o[7:5] == tsr_pkg::ERR_PENALTY_WAIT)
            |-> status_o[tsr_pkg::ST_BUSY_BIT];
    endproperty
    a_lock_codes_busy: assert property (p_lock_codes_busy) else $error("lock code shown without busy");

    property p_penalty_busy;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (processing_i || penalty_i) |=> status_o[tsr_pkg::ST_BUSY_BIT];
    endproperty
    a_penalty_busy: assert property (p_penalty_busy) else $error("busy missing while processing");

    property p_verified_sticky;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        challenge_ok_i |=> ##1 status_o[tsr_pkg::ST_VERIFIED_BIT] [*8];
    endproperty
    a_verified_sticky: assert property (p_verified_sticky) else $error("verified flag not held");

    property p_avail;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_done_i |=> ##1 status_o[tsr_pkg::ST_AVAIL_BIT] == $past(cmd_has_output_i, 2);
    endproperty
    a_avail: assert property (p_avail) else $error("output flag wrong after completion");

    property p_err_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !cmd_done_i |=> $stable(err_code);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error code changed without command");

    property p_err_legal;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        status_o[7:5] <= tsr_pkg::ERR_AUTH_FAIL;
    endproperty
    a_err_legal: assert property (p_err_legal) else $error("unused error code shown");

    property p_status_read_acked;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == tsr_pkg::BUS_ADDR && scl_fall && !start_seen && !stop_seen && bit_cnt == tsr_pkg::BYTE_BITS
            && addr_match && addr_sel && addr_rd) |=> (state == tsr_pkg::BUS_ACK && sda_oe_o);
    endproperty
    a_status_read_acked: assert property (p_status_read_acked) else $error("status read not acknowledged");

    property p_ack_legal;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(state == tsr_pkg::BUS_ACK) |-> addr_match && !(addr_sel && !addr_rd)
            && !(!addr_sel && $past(busy_o));
    endproperty
    a_ack_legal: assert property (p_ack_legal) else $error("illegal address acknowledged");

    property p_one_byte;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == tsr_pkg::BUS_SEND) |-> bit_cnt <= tsr_pkg::LAST_BIT;
    endproperty
    a_one_byte: assert property (p_one_byte) else $error("more than one status byte sent");
endmodule

// [hdl/tsr_pkg.sv]
// Constants for the 2-wire status register readout block
// What this block does
// - Status reads answered always, even busy or locked
// - One status byte returned after address acknowledge
// - Bit 0 set when output bytes wait
// - Bit 1 set while processing or penalised
// - Bit 2 sticky after challenge reply succeeds
// - Bits 3 and 4 always read zero
// - Bits 5 to 7 hold error code
// - Codes: 0 ok, 2 malformed, 4 authentication
// - Code 1 lockout until reset, busy shown
// - Code 3 timed penalty, busy shown
// - Writes to status register are not acknowledged
// - Multi-byte integers travel most significant first
// - Byte arrays travel in index order
// - Bits within a byte go MSB first
// - Address upper six bits must match stored field
// - Busy device refuses command or data addresses
package tsr_pkg;
    localparam logic [7:0] DEV_ADDR_RST = 8'hc0;
    // Address byte fields
    localparam int ADDR_RW_BIT = 0;
    localparam int ADDR_SEL_BIT = 1;
    localparam int ADDR_CMP_LSB = 2;
    // Status byte fields
    localparam int ST_AVAIL_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_VERIFIED_BIT = 2;
    localparam int ST_RSVD_LSB = 3;
    localparam int ST_RSVD_MSB = 4;
    localparam int ST_ERR_LSB = 5;
    localparam int ST_ERR_MSB = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Error codes
    localparam logic [2:0] ERR_OK = 3'h0;
    localparam logic [2:0] ERR_RESET_LOCKOUT = 3'h1;
    localparam logic [2:0] ERR_MALFORMED = 3'h2;
    localparam logic [2:0] ERR_PENALTY_WAIT = 3'h3;
    localparam logic [2:0] ERR_AUTH_FAIL = 3'h4;
    // Bit counting
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [4:0] {
        BUS_IDLE = 5'b00001,
        BUS_ADDR = 5'b00010,
        BUS_ACK = 5'b00100,
        BUS_SEND = 5'b01000,
        BUS_SKIP = 5'b10000
    } tsr_bus_state_t;
endpackage

// [hdl/tsr_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tsr_pin_sync #(
    parameter int STAGES = tsr_pkg::SYNC_STAGES,
    parameter logic INIT = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [STAGES-1:0] stage;

    if (STAGES < 3)
    begin : g_stage_check
        $error("tsr_pin_sync needs at least three stages");
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            stage <= {STAGES{INIT}};
        else
            stage <= {stage[STAGES-2:0], pin_i};
    end

    // Level follows only when the last two stages agree
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            level_o <= INIT;
        else if (stage[STAGES-1] == stage[STAGES-2])
            level_o <= stage[STAGES-1];
    end
endmodule

// [bench/tsr_twi_master.sv]
// Behavioural 2-wire bus master driving the status slave
`timescale 1ns/1ps
module tsr_twi_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    localparam int HALF = 6;
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        sda_pull_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_pull_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_pull_o = 1'b0;
        tick(HALF);
    endtask
    // Data moves only while the clock is low, clear of its fall
    task automatic bit_out(input logic b);
        tick(2);
        sda_pull_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask
    task automatic bit_in(output logic b);
        tick(2);
        sda_pull_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        b = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(a);
        ack = (a === 1'b0);
    endtask
    // One byte then a not-acknowledge, as a status read allows
    task automatic recv_byte(output logic [7:0] v);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_in(b);
            v[i] = b;
        end
        bit_out(1'b1);
    endtask
endmodule

// [bench/tb_tsr_status_slave.sv]
// Self-checking bench for the 2-wire status slave
`timescale 1ns/1ps
module tb_tsr_status_slave;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic scl, sda_pull, sda_o, sda_oe_o, busy_o, cmd_addr_hit_o;
    int hit_count = 0;
    logic cmd_start_i = 1'b0, cmd_done_i = 1'b0, cmd_has_output_i = 1'b0;
    logic processing_i = 1'b0, penalty_i = 1'b0, challenge_ok_i = 1'b0;
    logic [2:0] cmd_err_i = 3'h0;
    logic [7:0] status_o;
    wire sda = ((sda_oe_o & ~sda_o) | sda_pull) ? 1'b0 : 1'b1;
    int failures = 0;
    int n_compared = 0;
    initial
    begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) if (cmd_addr_hit_o === 1'b1) hit_count <= hit_count + 1;
    tsr_twi_master m (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(sda_pull));
    tsr_status_slave dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cmd_start_i(cmd_start_i), .cmd_done_i(cmd_done_i),
        .cmd_has_output_i(cmd_has_output_i), .cmd_err_i(cmd_err_i), .processing_i(processing_i),
        .penalty_i(penalty_i), .challenge_ok_i(challenge_ok_i), .status_o(status_o), .busy_o(busy_o),
        .cmd_addr_hit_o(cmd_addr_hit_o));
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] st(input logic [2:0] e, input logic ver, input logic bsy, input logic av);
        return {e, 2'b00, ver, bsy, av};
    endfunction
    task automatic settle();
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic do_reset(input int n);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b1;
        repeat (n) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        settle();
    endtask
    task automatic finish_cmd(input logic [2:0] e, input logic out);
        @(negedge sys_clk_i);
        cmd_done_i = 1'b1;
        cmd_err_i = e;
        cmd_has_output_i = out;
        @(negedge sys_clk_i);
        cmd_done_i = 1'b0;
        settle();
    endtask
    task automatic pulse_start();
        @(negedge sys_clk_i);
        cmd_start_i = 1'b1;
        @(negedge sys_clk_i);
        cmd_start_i = 1'b0;
        settle();
    endtask
    task automatic probe(input logic [7:0] a, input logic exp);
        logic ack;
        int h;
        h = hit_count;
        m.start();
        m.send_byte(a, ack);
        m.stop();
        check("address ack", {7'h00, exp}, {7'h00, ack});
        check("command hit", {7'h00, exp & ~a[1]}, 8'(hit_count - h));
    endtask
    task automatic read_status(input logic [7:0] e);
        logic ack;
        logic [7:0] b;
        m.start();
        m.send_byte(8'hc3, ack);
        m.recv_byte(b);
        m.stop();
        check("status ack", 8'h01, {7'h00, ack});
        check("status byte", e, b);
        check("status port", e, status_o);
    endtask
    task automatic sc_reset();
        check("reset status", 8'h00, status_o);
        check("reset busy", 8'h00, {7'h00, busy_o});
        read_status(8'h00);
    endtask
    task automatic sc_avail();
        finish_cmd(3'h0, 1'b1);
        read_status(st(3'h0, 1'b0, 1'b0, 1'b1));
        pulse_start();
        read_status(8'h00);
        finish_cmd(3'h0, 1'b0);
        read_status(8'h00);
        // Completion with output wins over a new start in one cycle
        @(negedge sys_clk_i);
        cmd_start_i = 1'b1;
        cmd_done_i = 1'b1;
        cmd_has_output_i = 1'b1;
        @(negedge sys_clk_i);
        cmd_start_i = 1'b0;
        cmd_done_i = 1'b0;
        settle();
        read_status(st(3'h0, 1'b0, 1'b0, 1'b1));
        pulse_start();
    endtask
    task automatic sc_busy();
        processing_i = 1'b1;
        settle();
        read_status(st(3'h0, 1'b0, 1'b1, 1'b0));
        probe(8'hc0, 1'b0);
        processing_i = 1'b0;
        penalty_i = 1'b1;
        settle();
        read_status(st(3'h0, 1'b0, 1'b1, 1'b0));
        penalty_i = 1'b0;
        settle();
    endtask
    task automatic sc_errors();
        logic [2:0] e;
        logic b;
        for (int c = 0; c < 8; c++)
        begin
            finish_cmd(c[2:0], 1'b0);
            e = (c > 4) ? 3'h2 : c[2:0];
            b = (e == 3'h1) || (e == 3'h3);
            read_status(st(e, 1'b0, b, 1'b0));
            check("busy port", {7'h00, b}, {7'h00, busy_o});
        end
        finish_cmd(3'h4, 1'b1);
        pulse_start();
        read_status(st(3'h4, 1'b0, 1'b0, 1'b0));
        finish_cmd(3'h0, 1'b0);
    endtask
    task automatic sc_verified();
        @(negedge sys_clk_i);
        challenge_ok_i = 1'b1;
        @(negedge sys_clk_i);
        challenge_ok_i = 1'b0;
        settle();
        read_status(st(3'h0, 1'b1, 1'b0, 1'b0));
        finish_cmd(3'h2, 1'b1);
        read_status(st(3'h2, 1'b1, 1'b0, 1'b1));
        do_reset(2);
        read_status(8'h00);
    endtask
    task automatic sc_address();
        int h;
        h = hit_count;
        probe(8'hc2, 1'b0);
        probe(8'h83, 1'b0);
        probe(8'hc7, 1'b0);
        probe(8'hc1, 1'b1);
        probe(8'hc0, 1'b1);
        check("command addresses seen", 8'h02, 8'(hit_count - h));
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        settle();
        sc_reset();
        sc_avail();
        sc_busy();
        sc_errors();
        sc_verified();
        sc_address();
        give_verdict();
    end
endmodule
